// >>> src/pstr_pkg.sv
// constants and types for the program sequencer with return stack and table read
`default_nettype none
package pstr_pkg;
   localparam int PSTR_PC_W      = 14;               // 16K word space
   localparam int PSTR_WORD_W    = 16;
   localparam int PSTR_DATA_W    = 8;
   localparam int PSTR_STACK_LVL = 12;
   localparam int PSTR_SP_W      = 4;
   localparam int PSTR_TBH_W     = 8;                // implemented holder bits
   localparam logic [13:0] PSTR_RESET_VEC = 14'h0000;
   localparam logic [13:0] PSTR_INT_VEC   = 14'h0004;
   localparam logic [3:0]  PSTR_SP_RESET  = 4'h0;
   // register offsets on the plain port
   localparam logic [3:0] PSTR_REG_PC_LOW   = 4'h0;
   localparam logic [3:0] PSTR_REG_TBLP     = 4'h1;
   localparam logic [3:0] PSTR_REG_TBHP     = 4'h2;
   localparam logic [3:0] PSTR_REG_TAB_HOLD = 4'h3;
   localparam logic [3:0] PSTR_REG_STATUS   = 4'h4;
   localparam logic [3:0] PSTR_REG_BANK     = 4'h5;
   localparam logic [3:0] PSTR_REG_ACC      = 4'h6;
   localparam logic [3:0] PSTR_REG_INFO     = 4'h7;
   // status field positions
   localparam int PSTR_ST_C  = 0;
   localparam int PSTR_ST_AC = 1;
   localparam int PSTR_ST_Z  = 2;
   localparam int PSTR_ST_OV = 3;
   typedef enum logic [3:0] {
      PSTR_OP_NOP      = 4'h0,
      PSTR_OP_BRANCH   = 4'h1,
      PSTR_OP_CALL     = 4'h2,
      PSTR_OP_SUB_EXIT = 4'h3,
      PSTR_OP_INT_EXIT = 4'h4,
      PSTR_OP_SKIP     = 4'h5,
      PSTR_OP_TAB      = 4'h6,
      PSTR_OP_TABL     = 4'h7,
      PSTR_OP_LTAB     = 4'h8,
      PSTR_OP_LTABL    = 4'h9,
      PSTR_OP_ALU      = 4'hA
   } pstr_op_t;
   typedef enum logic [2:0] {
      PSTR_AL_ADD = 3'h0,
      PSTR_AL_SUB = 3'h1,
      PSTR_AL_AND = 3'h2,
      PSTR_AL_OR  = 3'h3,
      PSTR_AL_XOR = 3'h4,
      PSTR_AL_RL  = 3'h5,
      PSTR_AL_INC = 3'h6,
      PSTR_AL_DEC = 3'h7
   } pstr_alu_t;
   typedef enum logic [1:0] {
      PSTR_S_RUN   = 2'b00,
      PSTR_S_DUMMY = 2'b01,
      PSTR_S_TABLE = 2'b10
   } pstr_state_t;
endpackage : pstr_pkg
`default_nettype wire

// >>> src/pstr_alu_if.sv
// interface carrying operands and results between sequencer and datapath
`default_nettype none
interface pstr_alu_if
   import pstr_pkg::*;
   ();
   pstr_alu_t        op;
   logic [7:0]       a;
   logic [7:0]       b;
   logic             cin;
   logic [7:0]       y;
   logic [3:0]       flags;
   modport seq (output op, output a, output b, output cin, input y, input flags);
   modport alu (input op, input a, input b, input cin, output y, output flags);
endinterface : pstr_alu_if
`default_nettype wire

// >>> src/pstr_alu.sv
// eight bit datapath producing a result and status flags
`default_nettype none
module pstr_alu
   import pstr_pkg::*;
   (
   pstr_alu_if.alu   bus
);
   logic [8:0] sum_w;
   logic [4:0] half_w;
   logic [7:0] rhs_w;
   logic       carry_w;
   // eight bit adder shared by add, sub, inc, dec
   assign rhs_w   = (bus.op == PSTR_AL_SUB) ? ~bus.b :
                    (bus.op == PSTR_AL_INC) ? 8'h01 :
                    (bus.op == PSTR_AL_DEC) ? 8'hFF : bus.b;
   assign carry_w = (bus.op == PSTR_AL_SUB) ? 1'b1 : bus.cin & (bus.op == PSTR_AL_ADD);
   assign sum_w   = {1'b0, bus.a} + {1'b0, rhs_w} + {8'h00, carry_w};
   assign half_w  = {1'b0, bus.a[3:0]} + {1'b0, rhs_w[3:0]} + {4'h0, carry_w};
   // result select
   always_comb begin
      unique case (bus.op)
         PSTR_AL_AND: bus.y = bus.a & bus.b;
         PSTR_AL_OR:  bus.y = bus.a | bus.b;
         PSTR_AL_XOR: bus.y = bus.a ^ bus.b;
         PSTR_AL_RL:  bus.y = {bus.a[6:0], bus.a[7]};
         default:     bus.y = sum_w[7:0];
      endcase
   end
   // carry/borrow, half carry, zero, overflow
   assign bus.flags[PSTR_ST_C]  = (bus.op == PSTR_AL_RL) ? bus.a[7] : sum_w[8];
   assign bus.flags[PSTR_ST_AC] = half_w[4];
   assign bus.flags[PSTR_ST_Z]  = (bus.y == 8'h00);
   assign bus.flags[PSTR_ST_OV] = (bus.a[7] == rhs_w[7]) && (sum_w[7] != bus.a[7]);
endmodule : pstr_alu
`default_nettype wire

// >>> src/pstr_stack.sv
// twelve level circular return address stack
`default_nettype none
module pstr_stack
   import pstr_pkg::*;
   #(
   parameter int LEVELS = PSTR_STACK_LVL
)(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              push,
   input  wire logic              pop,
   input  wire logic [13:0]       push_addr,
   output logic [13:0]            top_addr,
   output logic                   full
);
   logic [13:0]          mem_q [LEVELS];
   logic [PSTR_SP_W-1:0] wr_q;
   logic [PSTR_SP_W-1:0] cnt_q;
   logic [PSTR_SP_W-1:0] wr_inc;
   logic [PSTR_SP_W-1:0] wr_dec;
   // refuse depths the four bit pointer cannot serve
   if (LEVELS < 2 || LEVELS > 15) begin : g_bad_depth
      $error("stack depth out of range");
   end
   // wrap-around pointer arithmetic
   assign wr_inc   = (wr_q == PSTR_SP_W'(LEVELS - 1)) ? '0 : wr_q + 1'b1;
   assign wr_dec   = (wr_q == '0) ? PSTR_SP_W'(LEVELS - 1) : wr_q - 1'b1;
   assign top_addr = mem_q[wr_dec];
   assign full     = (cnt_q == PSTR_SP_W'(LEVELS));
   // pointer and level count, reset to top
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_q  <= PSTR_SP_RESET;
         cnt_q <= '0;
      end else if (push) begin
         wr_q  <= wr_inc;
         if (!full) cnt_q <= cnt_q + 1'b1;
      end else if (pop) begin
         wr_q  <= wr_dec;
         if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
      end
   end
   // storage, overwrites oldest on overflow
   always_ff @(posedge clk) begin
      if (push) mem_q[wr_q] <= push_addr;
   end
endmodule : pstr_stack
`default_nettype wire

// >>> src/pstr_seq.sv
// program sequencer: counter, return stack, table read, register port
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`default_nettype none
module pstr_seq
   import pstr_pkg::*;
   (
   input  wire logic              clk,
   input  wire logic              nrst,
   // instruction issue from decode
   input  wire logic              instr_valid,
   input  wire logic [3:0]        instr_op,
   input  wire logic [13:0]       instr_target,
   input  wire logic              skip_cond,
   input  wire logic [2:0]        alu_op,
   input  wire logic [7:0]        alu_operand,
   input  wire logic [7:0]        table_dest,
   input  wire logic              int_request,
   input  wire logic              int_enable,
   // program memory
   output logic [13:0]            pmem_addr,
   input  wire logic [15:0]       pmem_data,
   // register port
   input  wire logic [3:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [7:0]             reg_rdata,
   // execution status
   output logic                   fetch_valid,
   output logic [15:0]            fetch_word,
   output logic                   int_ack,
   output logic                   int_pending,
   output logic                   table_done,
   output logic [7:0]             table_dest_q,
   output logic [7:0]             table_low,
   output logic                   table_extended,
   output logic                   table_last_page
);
   parameter logic [7:0] PSTR_INFO_ID = 8'h5A;   // arbitrary identity value

   pstr_alu_if alu_bus ();
   pstr_state_t  state_q, state_d;
   logic [7:0]   pc_lo_q, pc_lo_d;
   logic [4:0]   pch_q, pch_d;
   logic         bank_q, bank_d;
   logic [7:0]   tblp_q;
   logic [7:0]   tbhp_q;
   logic [7:0]   thold_q;
   logic [3:0]   status_q;
   logic [7:0]   acc_q;
   logic         irq_q;
   logic         ack_q;
   logic         fv_q;
   logic [15:0]  fw_q;
   logic         tdone_q;
   logic [7:0]   tdest_q;
   logic [7:0]   tlow_q;
   logic         text_q;
   logic         tlast_q;
   logic [7:0]   rdata_q;
   logic [13:0]  addr_q;
   logic         ext_q, last_q;
   logic [13:0]  pc_w;
   logic [13:0]  pc_inc_w;
   logic [13:0]  ret_w;
   logic         full_w;
   logic         push_w, pop_w;
   logic         take_int_w;
   logic         go_w;
   logic         is_exit_w, is_call_w, is_br_w, is_skip_w, is_tab_w, is_alu_w;
   logic         lo_wr_w;
   logic [13:0]  tab_addr_w;
   logic [7:0]   rd_mux_w;

   // full program counter view
   assign pc_w     = {bank_q, pch_q, pc_lo_q};
   assign pc_inc_w = pc_w + 14'h0001;

   // instruction class decode
   assign go_w      = instr_valid && (state_q == PSTR_S_RUN);
   assign is_br_w   = go_w && (instr_op == PSTR_OP_BRANCH);
   assign is_call_w = go_w && (instr_op == PSTR_OP_CALL);
   assign is_exit_w = go_w && (instr_op == PSTR_OP_SUB_EXIT || instr_op == PSTR_OP_INT_EXIT);
   assign is_skip_w = go_w && (instr_op == PSTR_OP_SKIP) && skip_cond;
   assign is_tab_w  = go_w && (instr_op inside {PSTR_OP_TAB, PSTR_OP_TABL, PSTR_OP_LTAB, PSTR_OP_LTABL});
   assign is_alu_w  = go_w && (instr_op == PSTR_OP_ALU);
   assign lo_wr_w   = reg_wr && (reg_addr == PSTR_REG_PC_LOW);

   // interrupt acknowledge withheld while stack full or a call, exit or low byte jump wins
   assign take_int_w = irq_q && int_enable && !full_w && go_w
                       && !is_call_w && !is_exit_w && !lo_wr_w;

   // stack control
   assign push_w = is_call_w || take_int_w;
   assign pop_w  = is_exit_w;

   // table address: last page variants use the top page
   assign tab_addr_w = (instr_op == PSTR_OP_TABL || instr_op == PSTR_OP_LTABL) ?
                       {6'h3F, tblp_q} : {tbhp_q[5:0], tblp_q};

   pstr_stack #(
      .LEVELS    (PSTR_STACK_LVL)
   ) u_stack (
      .clk       (clk),
      .nrst      (nrst),
      .push      (push_w),
      .pop       (pop_w),
      .push_addr (pc_inc_w),
      .top_addr  (ret_w),
      .full      (full_w)
   );

   // datapath hookup
   assign alu_bus.op  = pstr_alu_t'(alu_op);
   assign alu_bus.a   = acc_q;
   assign alu_bus.b   = alu_operand;
   assign alu_bus.cin = status_q[PSTR_ST_C];

   pstr_alu u_alu (
      .bus (alu_bus)
   );

   // next program counter and sequencing state
   always_comb begin
      state_d = state_q;
      pc_lo_d = pc_lo_q;
      pch_d   = pch_q;
      bank_d  = bank_q;
      unique case (state_q)
         PSTR_S_RUN: begin
            if (lo_wr_w) begin
               pc_lo_d = reg_wdata;
               state_d = PSTR_S_DUMMY;
            end else if (take_int_w) begin
               {bank_d, pch_d, pc_lo_d} = PSTR_INT_VEC;
               state_d = PSTR_S_DUMMY;
            end else if (is_br_w || is_call_w) begin
               {bank_d, pch_d, pc_lo_d} = instr_target;
               state_d = PSTR_S_DUMMY;
            end else if (is_exit_w) begin
               {bank_d, pch_d, pc_lo_d} = ret_w;
               state_d = PSTR_S_DUMMY;
            end else if (is_skip_w) begin
               {bank_d, pch_d, pc_lo_d} = pc_w + 14'h0002;
               state_d = PSTR_S_DUMMY;
            end else if (is_tab_w) begin
               state_d = PSTR_S_TABLE;
            end else if (go_w) begin
               {bank_d, pch_d, pc_lo_d} = pc_inc_w;
            end
         end
         PSTR_S_DUMMY: begin
            state_d = PSTR_S_RUN;
         end
         PSTR_S_TABLE: begin
            {bank_d, pch_d, pc_lo_d} = pc_inc_w;
            state_d = PSTR_S_RUN;
         end
         default: state_d = PSTR_S_RUN;
      endcase
   end

   // sequencer registers, reset to vector zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= PSTR_S_RUN;
         pc_lo_q <= PSTR_RESET_VEC[7:0];
         pch_q   <= PSTR_RESET_VEC[12:8];
         bank_q  <= PSTR_RESET_VEC[13];
      end else begin
         state_q <= state_d;
         pc_lo_q <= pc_lo_d;
         pch_q   <= pch_d;
         bank_q  <= bank_d;
      end
   end

   // program memory address, dummy cycles fetch the new target
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_q <= PSTR_RESET_VEC;
         ext_q  <= 1'b0;
         last_q <= 1'b0;
      end else begin
         addr_q <= is_tab_w ? tab_addr_w : {bank_d, pch_d, pc_lo_d};
         ext_q  <= (instr_op == PSTR_OP_LTAB || instr_op == PSTR_OP_LTABL);
         last_q <= (instr_op == PSTR_OP_TABL || instr_op == PSTR_OP_LTABL);
      end
   end

   // fetched word presented downstream, squashed in dummy cycles
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fv_q <= 1'b0;
         fw_q <= 16'h0000;
      end else begin
         fv_q <= (state_d == PSTR_S_RUN) && (state_q == PSTR_S_RUN);
         fw_q <= pmem_data;
      end
   end

   // table completion: low byte out, high byte to holder
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tdone_q <= 1'b0;
         tlow_q  <= 8'h00;
         tdest_q <= 8'h00;
         text_q  <= 1'b0;
         tlast_q <= 1'b0;
      end else begin
         tdone_q <= (state_q == PSTR_S_TABLE);
         if (is_tab_w) tdest_q <= table_dest;
         if (state_q == PSTR_S_TABLE) begin
            tlow_q  <= pmem_data[7:0];
            text_q  <= ext_q;
            tlast_q <= last_q;
         end
      end
   end

   // software registers; hardware table load wins over a write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tblp_q   <= 8'h00;
         tbhp_q   <= 8'h00;
         thold_q  <= 8'h00;
         status_q <= 4'h0;
         acc_q    <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == PSTR_REG_TBLP) tblp_q <= reg_wdata;
         if (reg_wr && reg_addr == PSTR_REG_TBHP) tbhp_q <= reg_wdata;
         if (state_q == PSTR_S_TABLE)
            thold_q <= pmem_data[15:8] & 8'((1 << PSTR_TBH_W) - 1);
         else if (reg_wr && reg_addr == PSTR_REG_TAB_HOLD)
            thold_q <= reg_wdata;
         if (is_alu_w) begin
            acc_q    <= alu_bus.y;
            status_q <= alu_bus.flags;
         end else begin
            if (reg_wr && reg_addr == PSTR_REG_ACC) acc_q <= reg_wdata;
            if (reg_wr && reg_addr == PSTR_REG_STATUS) status_q <= reg_wdata[3:0];
         end
      end
   end

   // interrupt flag: set wins over the clear by acknowledge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
         ack_q <= 1'b0;
      end else begin
         irq_q <= (int_request && int_enable) || (irq_q && !take_int_w);
         ack_q <= take_int_w;
      end
   end

   // read mux; stack is never visible here
   assign rd_mux_w = (reg_addr == PSTR_REG_PC_LOW)   ? pc_lo_q :
                     (reg_addr == PSTR_REG_TBLP)     ? tblp_q :
                     (reg_addr == PSTR_REG_TBHP)     ? tbhp_q :
                     (reg_addr == PSTR_REG_TAB_HOLD) ? thold_q :
                     (reg_addr == PSTR_REG_STATUS)   ? {4'h0, status_q} :
                     (reg_addr == PSTR_REG_BANK)     ? {2'b00, bank_q, pch_q} :
                     (reg_addr == PSTR_REG_ACC)      ? acc_q :
                     (reg_addr == PSTR_REG_INFO)     ? PSTR_INFO_ID : 8'h00;

   // read data stands one cycle after the strobe only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) rdata_q <= 8'h00;
      else       rdata_q <= reg_rd ? rd_mux_w : 8'h00;
   end

   assign pmem_addr       = addr_q;
   assign reg_rdata       = rdata_q;
   assign fetch_valid     = fv_q;
   assign fetch_word      = fw_q;
   assign int_ack         = ack_q;
   assign int_pending     = irq_q;
   assign table_done      = tdone_q;
   assign table_dest_q    = tdest_q;
   assign table_low       = tlow_q;
   assign table_extended  = text_q;
   assign table_last_page = tlast_q;
endmodule : pstr_seq
`default_nettype wire

// >>> test/pstr_seq_checker.sv
// port assertions for the program sequencer
`default_nettype none
module pstr_seq_checker
   import pstr_pkg::*;
   (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        instr_valid,
   input wire logic [3:0]  instr_op,
   input wire logic [7:0]  table_dest,
   input wire logic [13:0] pmem_addr,
   input wire logic [15:0] pmem_data,
   input wire logic [3:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        fetch_valid,
   input wire logic        int_ack,
   input wire logic        int_pending,
   input wire logic        table_done,
   input wire logic [7:0]  table_dest_q,
   input wire logic [7:0]  table_low,
   input wire logic        table_extended,
   input wire logic        table_last_page
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [13:0] lo_tgt_q;
   logic        lo_wr;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // landing address of a low byte write, same page
   assign lo_wr = reg_wr && reg_addr == PSTR_REG_PC_LOW;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lo_tgt_q <= 14'h0000;
      end else if (lo_wr) begin
         lo_tgt_q <= {pmem_addr[13:8], reg_wdata};
      end
   end
   AST_RESET_VECTOR: assert property (!$past(nrst) |-> pmem_addr == 14'h0000)
      else $error("fetch does not start at address zero");
   AST_PC_LOW_JUMP: assert property (lo_wr |-> ##[1:3] pmem_addr == lo_tgt_q)
      else $error("low byte write did not jump in page");
   AST_PC_LOW_DUMMY: assert property (lo_wr |-> ##[1:3] !fetch_valid)
      else $error("low byte write without dummy cycle");
   AST_TABLE_TWO_CYCLES: assert property (table_done |-> $past(instr_valid, 2) && $past(instr_op, 2) >= 4'h6
      && $past(instr_op, 2) <= 4'h9) else $error("table result not two cycles after issue");
   AST_TABLE_LOW: assert property (table_done |-> table_low == $past(pmem_data[7:0]))
      else $error("table low byte differs from fetched word");
   AST_TABLE_DEST: assert property (table_done |-> table_dest_q == $past(table_dest, 2))
      else $error("table destination not carried");
   AST_TABLE_KIND: assert property (table_done |-> table_extended == ($past(instr_op, 2) >= 4'h8)
      && table_last_page == $past(instr_op[0], 2)) else $error("table variant flags wrong");
   AST_ACK_VECTOR: assert property (int_ack |-> ##[0:2] pmem_addr == PSTR_INT_VEC)
      else $error("acknowledge without vector load");
   AST_ACK_PENDING: assert property (int_ack |-> $past(int_pending))
      else $error("acknowledge without pending request");
   AST_ACK_PULSE: assert property (int_ack |=> !int_ack)
      else $error("acknowledge longer than one cycle");
   AST_RDATA_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read answer cycle");
   // main scenarios seen
   COV_TABLE: cover property (table_done && table_extended);
   COV_ACK: cover property (int_ack);
   COV_PC_LOW: cover property (lo_wr);
endmodule : pstr_seq_checker
bind pstr_seq pstr_seq_checker chk_u (.clk, .nrst, .instr_valid, .instr_op, .table_dest, .pmem_addr, .pmem_data,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fetch_valid, .int_ack, .int_pending, .table_done,
   .table_dest_q, .table_low, .table_extended, .table_last_page);
`default_nettype wire

// >>> test/pstr_pmem_model.sv
// program memory model, combinational read
`default_nettype none
module pstr_pmem_model (
   input  wire logic [13:0] addr,
   output logic      [15:0] data
);
   timeunit 1ns;
   timeprecision 1ns;
   // 16K words of 16 bits, each address distinct
   assign data = {addr[7:0] ^ 8'h5C, addr[13:6]};
endmodule : pstr_pmem_model
`default_nettype wire

// >>> test/pstr_seq_bench.sv
// self-checking bench for the program sequencer
`default_nettype none
module pstr_seq_bench
   import pstr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, nrst, instr_valid, skip_cond, int_request, int_enable, reg_wr, reg_rd;
   logic [3:0]  instr_op, reg_addr;
   logic [2:0]  alu_op;
   logic [7:0]  alu_operand, table_dest, reg_wdata, reg_rdata, table_dest_q, table_low;
   logic [13:0] instr_target, pmem_addr, a, ea, cur;
   logic [15:0] pmem_data, w, fw;
   logic        fetch_valid, int_ack, int_pending, table_done, table_extended, table_last_page, tex, tlp;
   logic [7:0]  rv, got, tlo, tdq, lp, hp;
   integer      seed;
   int          miscompares, comparisons, dummies, acks, dones, d0, n, dn;
   logic [13:0] stk[$];
   pstr_seq dut_u (.clk, .nrst, .instr_valid, .instr_op, .instr_target, .skip_cond, .alu_op, .alu_operand,
      .table_dest, .int_request, .int_enable, .pmem_addr, .pmem_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .fetch_valid, .fetch_word(fw), .int_ack, .int_pending, .table_done, .table_dest_q, .table_low,
      .table_extended, .table_last_page);
   pstr_pmem_model mem_u (.addr(pmem_addr), .data(pmem_data));
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // count acknowledges, capture table results
   always @(negedge clk) begin
      if (int_ack === 1'b1) acks++;
      if (table_done === 1'b1) begin
         dones++;
         tlo = table_low;
         tdq = table_dest_q;
         tex = table_extended;
         tlp = table_last_page;
      end
   end
   function automatic logic [15:0] word_at(logic [13:0] ad);
      return {ad[7:0] ^ 8'h5C, ad[13:6]};
   endfunction : word_at
   task automatic chk(logic [15:0] g, logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic note(string s);
      $display("test %s done", s);
   endtask : note
   // run c cycles, counting dummy fetches
   task automatic settle(int c);
      dummies = 0;
      repeat (c) begin
         @(posedge clk);
         #1;
         if (fetch_valid !== 1'b1) dummies++;
      end
   endtask : settle
   task automatic issue(logic [3:0] op, logic [13:0] tgt, logic cond);
      @(posedge clk);
      instr_op <= op;
      instr_target <= tgt;
      skip_cond <= cond;
      @(posedge clk);
      instr_op <= PSTR_OP_NOP;
      skip_cond <= 1'b0;
   endtask : issue
   task automatic wr(logic [3:0] ad, logic [7:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [3:0] ad, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   // fetch address must reach [lo, lo+span] within a few cycles
   task automatic land(logic [13:0] lo, logic [13:0] span);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 8 && !hit; i++) begin
         #1;
         hit = (pmem_addr >= lo && pmem_addr <= lo + span);
         if (!hit) @(posedge clk);
      end
      chk({2'b00, pmem_addr}, hit ? {2'b00, pmem_addr} : {2'b00, lo});
   endtask : land
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // watchdog
   initial begin
      #100000;
      miscompares++;
      end_of_test();
   end
   initial begin
      seed = 32'h327B;
      {miscompares, comparisons, acks, dones} = '0;
      {nrst, skip_cond, int_request, int_enable, reg_wr, reg_rd} = '0;
      instr_valid = 1'b1;
      instr_op = PSTR_OP_NOP;
      {instr_target, alu_op, alu_operand, table_dest, reg_addr, reg_wdata} = '0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      land(14'h0000, 14'h0001);
      @(posedge clk);
      #1;
      a = pmem_addr;
      @(posedge clk);
      #1;
      chk({2'b00, pmem_addr}, {2'b00, a + 14'h0001});
      chk(fw, word_at(a));
      rv = 8'($random(seed));
      wr(PSTR_REG_TAB_HOLD, rv);
      rd(PSTR_REG_TAB_HOLD, got);
      chk(got, rv);
      wr(4'hC, rv);
      rd(4'hC, got);
      chk(got, 0);
      note("registers");
      issue(PSTR_OP_SKIP, 0, 1'b0);
      settle(4);
      d0 = dummies;
      issue(PSTR_OP_SKIP, 0, 1'b1);
      settle(4);
      chk(dummies, d0 + 1);
      issue(PSTR_OP_BRANCH, 14'h0400, 1'b0);
      land(14'h0400, 14'h0004);
      settle(3);
      wr(PSTR_REG_PC_LOW, 8'hC3);
      land(14'h04C3, 14'h0000);
      settle(3);
      note("branches");
      wr(PSTR_REG_ACC, 8'hF0);
      alu_op <= PSTR_AL_ADD;
      alu_operand <= 8'h20;
      issue(PSTR_OP_ALU, 0, 1'b0);
      settle(2);
      rd(PSTR_REG_ACC, got);
      chk(got, 8'h10);
      rd(PSTR_REG_STATUS, got);
      chk(got[3:0], 4'h1);
      note("datapath");
      for (int op = 6; op <= 9; op++) begin
         lp = 8'($random(seed));
         hp = 8'($random(seed));
         rv = 8'($random(seed));
         wr(PSTR_REG_TBLP, lp);
         wr(PSTR_REG_TBHP, hp);
         table_dest <= rv;
         dn = dones;
         issue(op[3:0], 0, 1'b0);
         settle(3);
         ea = op[0] ? {6'h3F, lp} : {hp[5:0], lp};
         w = word_at(ea);
         chk(dones - dn, 1);
         chk(tlo, w[7:0]);
         chk(tdq, rv);
         chk({tex, tlp}, {op[3], op[0]});
         rd(PSTR_REG_TAB_HOLD, got);
         chk(got, w[15:8]);
      end
      note("table");
      cur = 14'h0600;
      issue(PSTR_OP_BRANCH, cur, 1'b0);
      land(cur, 14'h0004);
      settle(3);
      for (int k = 0; k < 13; k++) begin
         stk.push_back(cur);
         if (stk.size() > PSTR_STACK_LVL) stk.pop_front();
         cur = 14'h0800 + 14'(k * 'h40);
         issue(PSTR_OP_CALL, cur, 1'b0);
         land(cur, 14'h0004);
         settle(3);
      end
      n = acks;
      @(posedge clk);
      int_enable <= 1'b1;
      int_request <= 1'b1;
      @(posedge clk);
      int_request <= 1'b0;
      settle(8);
      chk(acks - n, 0);
      chk(int_pending, 1'b1);
      cur = stk.pop_back();
      issue(PSTR_OP_SUB_EXIT, 0, 1'b0);
      land(cur, 14'h003F);
      settle(6);
      chk(acks - n, 1);
      issue(PSTR_OP_INT_EXIT, 0, 1'b0);
      land(cur, 14'h003F);
      settle(3);
      while (stk.size() > 0) begin
         cur = stk.pop_back();
         issue(PSTR_OP_SUB_EXIT, 0, 1'b0);
         land(cur, 14'h003F);
         settle(3);
      end
      note("stack");
      end_of_test();
   end
endmodule : pstr_seq_bench
`default_nettype wire
